//--- hw/ocvs_map.vh
// Register map, field positions, reset values and timing for ocvs
`ifndef OCVS_MAP_VH
`define OCVS_MAP_VH
`define OCVS_CLK_KHZ 50000
`define OCVS_WD_TIME_MS 500
`define OCVS_A_CTRL 12'h000
`define OCVS_A_ERRMODE 12'h004
`define OCVS_A_LBCFG 12'h008
`define OCVS_A_HART 12'h00c
`define OCVS_A_STATUS 12'h010
`define OCVS_A_IRQ_STAT 12'h014
`define OCVS_A_IRQ_MASK 12'h018
`define OCVS_A_CH_BASE 12'h040
`define OCVS_CH_STRIDE_LSB 5
`define OCVS_CH_RANGE 3'h0
`define OCVS_CH_LIMIT 3'h1
`define OCVS_CH_SIM 3'h2
`define OCVS_CH_SUBST 3'h3
`define OCVS_CH_OUT 3'h4
`define OCVS_B_ACTIVE 0
`define OCVS_B_SIM_LSB 4
`define OCVS_B_SIMINV_LSB 8
`define OCVS_B_LB_LSB 4
`define OCVS_B_INV_LSB 8
`define OCVS_B_SCAN_LSB 4
`define OCVS_B_MIN_LSB 16
`define OCVS_B_HI_LSB 16
`define OCVS_B_INVAL 1
`define OCVS_EM_PASS 2'h0
`define OCVS_EM_SUBST 2'h1
`define OCVS_EM_HOLD 2'h2
`define OCVS_RST_MIN_UA 16'h0320
`define OCVS_RST_START 16'h2710
`define OCVS_RST_END 16'hc350
`define OCVS_RST_LOWER 16'h0000
`define OCVS_RST_UPPER 16'hea60
`define OCVS_PCT_FULL 14'h2710
`endif

//--- hw/ocvs_chan.v
// Per-channel source choice and error strategy
`default_nettype none
`include "ocvs_map.vh"
module ocvs_chan (
    input wire clk_sys,
    input wire resetn,
    input wire clk_en,
    input wire [15:0] bus_val,
    input wire sim_mode,
    input wire [15:0] sim_val,
    input wire sim_inv,
    input wire [15:0] subst_val,
    input wire [1:0] err_mode,
    input wire wd_expired,
    output reg [15:0] sel_val,
    output reg sel_inv
);
    wire [15:0] src_val;
    wire src_inv;
    wire err;
    reg [15:0] last_good_ff;
    ////////////////////////////////////////////////////////////////////////
    assign src_val = sim_mode ? sim_val : bus_val;
    assign src_inv = sim_mode ? sim_inv : bus_val[`OCVS_B_INVAL];
    // Line faults deliberately absent from the error term
    assign err = wd_expired | src_inv;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            last_good_ff <= 16'h0000;
        end else if (clk_en && !err) begin
            last_good_ff <= src_val;
        end
    end
    always @* begin
        sel_val = src_val;
        sel_inv = src_inv;
        if (err) begin
            case (err_mode)
                `OCVS_EM_PASS: begin
                    sel_val = src_val;
                    sel_inv = src_inv | wd_expired;
                end
                `OCVS_EM_SUBST: begin
                    sel_val = subst_val;
                    sel_inv = 1'b1;
                end
                `OCVS_EM_HOLD: begin
                    sel_val = last_good_ff;
                    sel_inv = 1'b1;
                end
                default: begin
                    sel_val = subst_val;
                    sel_inv = 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- hw/ocvs_scale.v
// Clamp to limits and scale counts to hundredths of a percent
`default_nettype none
`include "ocvs_map.vh"
module ocvs_scale (
    input wire [15:0] val,
    input wire [15:0] lower,
    input wire [15:0] upper,
    input wire [15:0] start,
    input wire [15:0] stop,
    output reg signed [16:0] pct
);
    reg [15:0] clamped;
    reg signed [16:0] diff;
    reg signed [16:0] den;
    reg signed [31:0] num;
    reg signed [31:0] quo;
    always @* begin
        clamped = {val[15:4], 4'h0};
        if (clamped < lower) begin
            clamped = lower;
        end
        if (clamped > upper) begin
            clamped = upper;
        end
        diff = $signed({1'b0, clamped}) - $signed({1'b0, start});
        den = $signed({1'b0, stop}) - $signed({1'b0, start});
        num = diff * $signed({1'b0, `OCVS_PCT_FULL});
        // Inverted or empty range gives zero rather than garbage
        if (den > 17'sd0) begin
            quo = num / den;
        end else begin
            quo = 32'sd0;
        end
        pct = quo[16:0];
    end
endmodule
`default_nettype wire

//--- hw/ocvs_top.v
// Four-channel output value selector with APB registers
//
// What this block does
// - Safe state after 0.5 s without traffic
// - Watchdog or invalid data applies error strategy
// - Line faults never trigger error strategy
// - Pass-through forwards live or simulated value
// - Substitute mode outputs configured substitute value
// - Hold mode keeps last valid value
// - Normal mode uses received bus value
// - Simulation mode uses simulation value instead
// - Lead breakage when current below threshold
// - Lead breakage reported in status bits
// - Start maps 0 percent, end 100 percent
// - Clamp values to lower limit
// - Clamp values to upper limit
// - Per-channel HART enable includes or excludes
// - Scanning on by default, per-channel off
// - Channel active follows module active setting
// - Substitute value always flagged invalid
//
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none
`include "ocvs_map.vh"
module ocvs_top #(
    parameter NCH = 4,
    parameter WD_CYCLES = `OCVS_WD_TIME_MS * `OCVS_CLK_KHZ
) (
    input wire clk_sys,
    input wire resetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Link from the communication unit
    input wire rx_valid,
    input wire [1:0] rx_chan,
    input wire [15:0] rx_value,
    // Loop current samples
    input wire cur_valid,
    input wire [16*NCH-1:0] cur_ua,
    // Per-channel results, watchdog flag and interrupt
    output reg [17*NCH-1:0] out_pct,
    output reg [NCH-1:0] out_inv,
    output reg [NCH-1:0] lead_break,
    output reg [NCH-1:0] hart_poll,
    output reg [NCH-1:0] hart_scan,
    output reg [NCH-1:0] chan_active,
    output reg wd_expired,
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration state
    reg active_ff;
    reg [NCH-1:0] sim_mode_ff;
    reg [NCH-1:0] sim_inv_ff;
    reg [2*NCH-1:0] err_mode_ff;
    reg [NCH-1:0] lb_en_ff;
    reg [15:0] min_ua_ff;
    reg [NCH-1:0] hart_en_ff;
    reg [NCH-1:0] scan_en_ff;
    reg [15:0] start_ff [0:NCH-1];
    reg [15:0] stop_ff [0:NCH-1];
    reg [15:0] lower_ff [0:NCH-1];
    reg [15:0] upper_ff [0:NCH-1];
    reg [15:0] sim_val_ff [0:NCH-1];
    reg [15:0] subst_ff [0:NCH-1];
    reg [15:0] bus_val_ff [0:NCH-1];

    reg [NCH:0] irq_stat_ff;
    reg [NCH:0] irq_mask_ff;
    reg [31:0] wd_cnt_ff;
    reg [NCH:0] nxt_irq_stat;
    reg [31:0] nxt_rdata;
    reg nxt_err;

    wire setup;
    wire wr_done;
    wire rd_done;
    wire ch_hit;
    wire [1:0] ch_sel;
    wire [2:0] ch_reg;
    wire [11:0] ch_off;
    wire wd_hit;
    wire [NCH-1:0] lb_now;
    wire [NCH-1:0] lb_rise;
    wire [NCH-1:0] sel_inv;
    wire [16*NCH-1:0] sel_val;
    wire [17*NCH-1:0] pct;
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    // Zero wait states: data and pready are set up in the setup cycle
    assign setup = psel & ~penable;
    assign wr_done = psel & penable & pready & pwrite;
    assign rd_done = psel & penable & pready & ~pwrite;
    // Base is not a window boundary, so decode the offset from it
    assign ch_off = paddr - `OCVS_A_CH_BASE;
    assign ch_hit = (paddr >= `OCVS_A_CH_BASE) && (ch_off[11:7] == 5'h00)
        && (ch_off[1:0] == 2'h0) && (ch_off[4:2] <= `OCVS_CH_OUT);
    assign ch_sel = ch_off[`OCVS_CH_STRIDE_LSB+1:`OCVS_CH_STRIDE_LSB];
    assign ch_reg = ch_off[4:2];

    // Unmapped reads return zero with pslverr
    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (ch_hit) begin
            case (ch_reg)
                `OCVS_CH_RANGE: nxt_rdata = {stop_ff[ch_sel], start_ff[ch_sel]};
                `OCVS_CH_LIMIT: nxt_rdata = {upper_ff[ch_sel], lower_ff[ch_sel]};
                `OCVS_CH_SIM: nxt_rdata = {16'h0000, sim_val_ff[ch_sel]};
                `OCVS_CH_SUBST: nxt_rdata = {16'h0000, subst_ff[ch_sel]};
                `OCVS_CH_OUT: begin
                    nxt_rdata = {15'h0000, out_pct[17*ch_sel +: 17]};
                    nxt_rdata[31] = out_inv[ch_sel];
                end
                default: nxt_err = 1'b1;
            endcase
        end else begin
            case (paddr)
                `OCVS_A_CTRL: begin
                    nxt_rdata[`OCVS_B_ACTIVE] = active_ff;
                    nxt_rdata[`OCVS_B_SIM_LSB +: NCH] = sim_mode_ff;
                    nxt_rdata[`OCVS_B_SIMINV_LSB +: NCH] = sim_inv_ff;
                end
                `OCVS_A_ERRMODE: nxt_rdata[2*NCH-1:0] = err_mode_ff;
                `OCVS_A_LBCFG: begin
                    nxt_rdata[NCH-1:0] = lb_en_ff;
                    nxt_rdata[31:`OCVS_B_MIN_LSB] = min_ua_ff;
                end
                `OCVS_A_HART: begin
                    nxt_rdata[NCH-1:0] = hart_en_ff;
                    nxt_rdata[`OCVS_B_SCAN_LSB +: NCH] = scan_en_ff;
                end
                `OCVS_A_STATUS: begin
                    nxt_rdata[0] = wd_expired;
                    nxt_rdata[`OCVS_B_LB_LSB +: NCH] = lead_break;
                    nxt_rdata[`OCVS_B_INV_LSB +: NCH] = out_inv;
                end
                `OCVS_A_IRQ_STAT: nxt_rdata[NCH:0] = irq_stat_ff;
                `OCVS_A_IRQ_MASK: nxt_rdata[NCH:0] = irq_mask_ff;
                default: nxt_err = 1'b1;
            endcase
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup & nxt_err;
            if (setup && !pwrite) begin
                prdata <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    // Rejected accesses leave every setting untouched
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            active_ff <= 1'b1;
            sim_mode_ff <= {NCH{1'b0}};
            sim_inv_ff <= {NCH{1'b0}};
            err_mode_ff <= {2*NCH{1'b0}};
            lb_en_ff <= {NCH{1'b0}};
            min_ua_ff <= `OCVS_RST_MIN_UA;
            hart_en_ff <= {NCH{1'b0}};
            scan_en_ff <= {NCH{1'b1}};
            irq_mask_ff <= {(NCH+1){1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                start_ff[i] <= `OCVS_RST_START;
                stop_ff[i] <= `OCVS_RST_END;
                lower_ff[i] <= `OCVS_RST_LOWER;
                upper_ff[i] <= `OCVS_RST_UPPER;
                sim_val_ff[i] <= 16'h0000;
                subst_ff[i] <= 16'h0000;
            end
        end else if (clk_en && wr_done && !pslverr) begin
            if (ch_hit) begin
                case (ch_reg)
                    `OCVS_CH_RANGE: begin
                        start_ff[ch_sel] <= pwdata[15:0];
                        stop_ff[ch_sel] <= pwdata[31:`OCVS_B_HI_LSB];
                    end
                    `OCVS_CH_LIMIT: begin
                        lower_ff[ch_sel] <= pwdata[15:0];
                        upper_ff[ch_sel] <= pwdata[31:`OCVS_B_HI_LSB];
                    end
                    `OCVS_CH_SIM: sim_val_ff[ch_sel] <= pwdata[15:0];
                    `OCVS_CH_SUBST: subst_ff[ch_sel] <= pwdata[15:0];
                    default: ;
                endcase
            end else begin
                case (paddr)
                    `OCVS_A_CTRL: begin
                        active_ff <= pwdata[`OCVS_B_ACTIVE];
                        sim_mode_ff <= pwdata[`OCVS_B_SIM_LSB +: NCH];
                        sim_inv_ff <= pwdata[`OCVS_B_SIMINV_LSB +: NCH];
                    end
                    `OCVS_A_ERRMODE: err_mode_ff <= pwdata[2*NCH-1:0];
                    `OCVS_A_LBCFG: begin
                        lb_en_ff <= pwdata[NCH-1:0];
                        min_ua_ff <= pwdata[31:`OCVS_B_MIN_LSB];
                    end
                    `OCVS_A_HART: begin
                        hart_en_ff <= pwdata[NCH-1:0];
                        scan_en_ff <= pwdata[`OCVS_B_SCAN_LSB +: NCH];
                    end
                    `OCVS_A_IRQ_MASK: irq_mask_ff <= pwdata[NCH:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Received process values and link watchdog
    // Words are stored raw; status bits decode per channel
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < NCH; i = i + 1) begin
                bus_val_ff[i] <= 16'h0000;
            end
        end else if (clk_en && rx_valid) begin
            bus_val_ff[rx_chan] <= rx_value;
        end
    end

    // Any received word counts as traffic, even an invalid one
    assign wd_hit = (wd_cnt_ff >= WD_CYCLES - 1);
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_ff <= 32'h0000_0000;
            wd_expired <= 1'b0;
        end else if (clk_en) begin
            if (rx_valid) begin
                wd_cnt_ff <= 32'h0000_0000;
                wd_expired <= 1'b0;
            end else if (wd_hit) begin
                wd_expired <= 1'b1;
            end else begin
                wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel value paths
    genvar g;

    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            ocvs_chan u_chan (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .clk_en(clk_en),
                .bus_val(bus_val_ff[g]),
                .sim_mode(sim_mode_ff[g]),
                .sim_val(sim_val_ff[g]),
                .sim_inv(sim_inv_ff[g]),
                .subst_val(subst_ff[g]),
                .err_mode(err_mode_ff[2*g +: 2]),
                .wd_expired(wd_expired),
                .sel_val(sel_val[16*g +: 16]),
                .sel_inv(sel_inv[g])
            );

            ocvs_scale u_scale (
                .val(sel_val[16*g +: 16]),
                .lower(lower_ff[g]),
                .upper(upper_ff[g]),
                .start(start_ff[g]),
                .stop(stop_ff[g]),
                .pct(pct[17*g +: 17])
            );

            assign lb_now[g] = lb_en_ff[g]
                && (cur_ua[16*g +: 16] < min_ua_ff);
        end
    endgenerate

    // A standing break raises one event, not one per sample
    assign lb_rise = lb_now & ~lead_break & {NCH{cur_valid}};

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_pct <= {17*NCH{1'b0}};
            out_inv <= {NCH{1'b0}};
            lead_break <= {NCH{1'b0}};
            hart_poll <= {NCH{1'b0}};
            hart_scan <= {NCH{1'b0}};
            chan_active <= {NCH{1'b0}};
        end else if (clk_en) begin
            out_pct <= pct;
            out_inv <= sel_inv;
            if (cur_valid) begin
                lead_break <= lb_now;
            end

            hart_poll <= hart_en_ff;
            hart_scan <= hart_en_ff & scan_en_ff;
            chan_active <= {NCH{active_ff}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a read of the status clears it, a new event wins
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_done && !pslverr && !ch_hit && paddr == `OCVS_A_IRQ_STAT) begin
            nxt_irq_stat = {(NCH+1){1'b0}};
        end
        nxt_irq_stat[0] = nxt_irq_stat[0] | (wd_hit & ~rx_valid & ~wd_expired);
        nxt_irq_stat[NCH:1] = nxt_irq_stat[NCH:1] | lb_rise;
    end

    // irq follows the next status, so it rises on the same edge as the status bit
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_stat_ff <= {(NCH+1){1'b0}};
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat_ff <= nxt_irq_stat;
            irq <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

endmodule
`default_nettype wire

//--- verification/ocvs_assertions.sv
// Port-level checks for the output value selector
`default_nettype none
module ocvs_assertions #(
    parameter NCH = 4,
    parameter WD_CYCLES = 25000000
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic cur_valid,
    input wire logic [NCH-1:0] out_inv,
    input wire logic [NCH-1:0] lead_break,
    input wire logic [NCH-1:0] hart_poll,
    input wire logic [NCH-1:0] hart_scan,
    input wire logic [NCH-1:0] chan_active,
    input wire logic wd_expired
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles since last word, saturating so it never wraps
    logic [31:0] quiet_ff;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet_ff <= 32'h0;
        end else if (clk_en) begin
            if (rx_valid) begin
                quiet_ff <= 32'h0;
            end else if (quiet_ff < WD_CYCLES) begin
                quiet_ff <= quiet_ff + 32'h1;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    chk_apb_answer: assert property (s_setup |=> s_access)
        else $error("No zero-wait answer");
    chk_ready_once: assert property (pready && clk_en |=> !pready)
        else $error("Ready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("Error outside access");
    chk_wd_quiet: assert property (
        quiet_ff < WD_CYCLES |-> !wd_expired)
        else $error("Watchdog fired early");
    chk_wd_expire: assert property (
        quiet_ff == WD_CYCLES |-> wd_expired)
        else $error("Watchdog missed");
    chk_wd_inv: assert property (wd_expired [*3] |-> &out_inv)
        else $error("Outputs valid in safe state");
    chk_lb_sample: assert property (
        !cur_valid |=> $stable(lead_break))
        else $error("Lead break moved without sample");
    chk_scan_sub: assert property (
        (hart_scan & ~hart_poll) == '0)
        else $error("Scan without HART");
    chk_active_all: assert property (
        &chan_active || !(|chan_active))
        else $error("Channel active split");
endmodule
`default_nettype wire

//--- verification/ocvs_comm_model.sv
// Model of the communication unit sending process words
`default_nettype none
module ocvs_comm_model (
    input wire logic clk_sys,
    output logic rx_valid,
    output logic [1:0] rx_chan,
    output logic [15:0] rx_value
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid = 1'b0;
        rx_chan = 2'h0;
        rx_value = 16'h0000;
    end
    // Lines scramble after the pulse so stale data never pass as valid
    task automatic send(input logic [1:0] ch, input logic [15:0] v,
                        input int gap);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_chan <= ch;
        rx_value <= v;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_chan <= ~ch;
        rx_value <= ~v;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the output value selector
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 4;
    localparam int WD = 1000;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'h84dd5d5b;
    logic cur_valid = 1'b0, e;
    logic [63:0] cur_ua = 64'h0;
    wire [31:0] prdata;
    wire pready, pslverr, rx_valid, wd_expired, irq;
    wire [1:0] rx_chan;
    wire [15:0] rx_value;
    wire [67:0] out_pct;
    wire [3:0] out_inv, lead_break, hart_poll, hart_scan, chan_active;
    int error_cnt = 0, check_count = 0, cyc = 0, g, v;
    int st[4], en[4], lo[4], hi[4], last[4];
    always #10 clk_sys = ~clk_sys;
    ocvs_comm_model comm_u (.clk_sys(clk_sys), .rx_valid(rx_valid),
        .rx_chan(rx_chan), .rx_value(rx_value));
    ocvs_top #(.NCH(NCH), .WD_CYCLES(WD)) dut_u (.clk_sys(clk_sys),
        .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_chan(rx_chan), .rx_value(rx_value), .cur_valid(cur_valid),
        .cur_ua(cur_ua), .out_pct(out_pct), .out_inv(out_inv),
        .lead_break(lead_break), .hart_poll(hart_poll),
        .hart_scan(hart_scan), .chan_active(chan_active),
        .wd_expired(wd_expired), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Low nibble carries status, so it never reaches the value
    function automatic int pct(input int c, input int w);
        w = w & 16'hfff0;
        if (w < lo[c]) w = lo[c];
        if (w > hi[c]) w = hi[c];
        if (en[c] <= st[c]) return 0;
        return (w - st[c]) * 10000 / (en[c] - st[c]);
    endfunction
    task automatic cmp(input string nm, input logic [31:0] x,
                       input logic [31:0] y);
        check_count++;
        if (y !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No wait count assumed; the bench timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(nm, x, rd);
    endtask
    task automatic chk_out(input int c, input int w, input logic inv);
        cmp("out_pct", pct(c, w) & 32'h1ffff, {15'h0, out_pct[17*c +: 17]});
        cmp("out_inv", {31'h0, inv}, {31'h0, out_inv[c]});
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int c = 0; c < 4; c++) begin
            st[c] = 10000;
            en[c] = 50000;
            lo[c] = 0;
            hi[c] = 60000;
        end
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int c = 0; c < 4; c++) chk_out(c, 0, 1'b0);
        cmp("active", 32'hf, {28'h0, chan_active});
        rdc("ctrl", 12'h000, 32'h1);
        rdc("lbcfg", 12'h008, 32'h03200000);
        rdc("hart", 12'h00c, 32'h000000f0);
        rdc("range", 12'h040, 32'hc3502710);
        rdc("limit", 12'h044, 32'hea600000);
        rdc("unmapped", 12'h054, 32'h0);
        cmp("slverr", 32'h1, {31'h0, e});
        $display("Test reset done");
        wr(12'h064, 32'hbb802ee0);
        lo[1] = 12000;
        hi[1] = 48000;
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            g = (i < 2) ? 1 : seed[1:0];
            v = (i < 2) ? i * 16'hfffd : seed[31:16] & 16'hfffd;
            comm_u.send(g[1:0], v[15:0], i % 3);
            repeat (4) @(posedge clk_sys);
            chk_out(g, v, 1'b0);
        end
        $display("Test scaling done");
        wr(12'h068, 32'h00007530);
        wr(12'h000, 32'h00000021);
        repeat (4) @(posedge clk_sys);
        chk_out(1, 30000, 1'b0);
        wr(12'h000, 32'h00000221);
        repeat (4) @(posedge clk_sys);
        chk_out(1, 30000, 1'b1);
        wr(12'h000, 32'h00000001);
        $display("Test simulation done");
        wr(12'h008, 32'h0320000f);
        @(posedge clk_sys);
        cur_ua <= {16'd900, 16'd0, 16'd800, 16'd799};
        cur_valid <= 1'b1;
        @(posedge clk_sys);
        cur_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cmp("lead_break", 32'h5, {28'h0, lead_break});
        cmp("inv_lb", 32'h0, {28'h0, out_inv});
        rdc("status", 12'h010, 32'h00000050);
        rdc("irq_stat", 12'h014, 32'h0000000a);
        rdc("irq_clr", 12'h014, 32'h0);
        $display("Test lead break done");
        wr(12'h004, 32'h000000e4);
        wr(12'h06c, 32'h00009c40);
        wr(12'h0ac, 32'h00009c40);
        for (int c = 0; c < 4; c++) begin
            last[c] = 16'h5000 + c * 16'h0800;
            comm_u.send(c[1:0], last[c][15:0], 0);
        end
        for (int c = 0; c < 4; c++) comm_u.send(c[1:0], 16'h7002, 0);
        repeat (4) @(posedge clk_sys);
        chk_out(0, 16'h7002, 1'b1);
        chk_out(1, 40000, 1'b1);
        chk_out(2, last[2], 1'b1);
        chk_out(3, 40000, 1'b1);
        $display("Test invalid data done");
        for (int c = 0; c < 4; c++) comm_u.send(c[1:0], 16'h3000, 0);
        wr(12'h018, 32'h00000001);
        repeat (WD - 20) @(posedge clk_sys);
        cmp("wd_early", 32'h0, {31'h0, wd_expired});
        repeat (30) @(posedge clk_sys);
        cmp("wd", 32'h1, {31'h0, wd_expired});
        cmp("irq", 32'h1, {31'h0, irq});
        chk_out(0, 16'h3000, 1'b1);
        chk_out(1, 40000, 1'b1);
        chk_out(2, 16'h3000, 1'b1);
        rdc("irq_wd", 12'h014, 32'h1);
        repeat (2) @(posedge clk_sys);
        cmp("irq_off", 32'h0, {31'h0, irq});
        comm_u.send(2'h1, 16'h3000, 0);
        repeat (4) @(posedge clk_sys);
        cmp("wd_off", 32'h0, {31'h0, wd_expired});
        chk_out(1, 16'h3000, 1'b0);
        $display("Test watchdog done");
        wr(12'h00c, 32'h00000035);
        wr(12'h000, 32'h00000000);
        repeat (2) @(posedge clk_sys);
        cmp("hart_poll", 32'h5, {28'h0, hart_poll});
        cmp("hart_scan", 32'h1, {28'h0, hart_scan});
        cmp("inactive", 32'h0, {28'h0, chan_active});
        $display("Test hart done");
        // A word sent while frozen must not reach the output
        clk_en <= 1'b0;
        comm_u.send(2'h1, 16'h8000, 0);
        repeat (3) @(posedge clk_sys);
        chk_out(1, 16'h3000, 1'b0);
        clk_en <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk_out(1, 16'h3000, 1'b0);
        $display("Test clock enable done");
        finish_test();
    end
endmodule
bind ocvs_top ocvs_assertions #(.NCH(NCH), .WD_CYCLES(WD_CYCLES)) chk_u (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .cur_valid(cur_valid), .out_inv(out_inv),
    .lead_break(lead_break), .hart_poll(hart_poll),
    .hart_scan(hart_scan), .chan_active(chan_active),
    .wd_expired(wd_expired));
`default_nettype wire
